// ---- verification/flash_dev_model.sv ----
module flash_dev_model #(
  // arbitrary identifier values, not those of any real part
  parameter logic [7:0] MAKER_CODE = 8'h3C,
  parameter logic [7:0] PART_CODE = 8'hC3
) (
  // flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [17:0] addr,
  input wire logic [7:0] dq,
  output logic drv,
  output logic [7:0] q,
  // supplies
  input wire logic supply_high,
  input wire logic id_voltage
);
  timeunit 1ns;
  timeprecision 100ps;

  // the latch is kept apart from mem, so only a program data write or an erase changes the array map
  logic [7:0] mem [256];
  logic [7:0] cmd;
  logic [7:0] wa;
  logic [7:0] ea;
  logic [7:0] pa;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    cmd = 8'h00;
    ea = 8'h00;
    pa = 8'h00;
    wa = 8'h00;
  end

  always @(negedge we_n) if (!ce_n) wa = addr[7:0];

  // state is stepped by write edges and cleared by the supply falling, so deselecting never ends an operation
  always @(posedge we_n) begin
    if (!ce_n && supply_high) begin
      if (cmd == 8'h40) begin
        mem[wa] = mem[wa] & dq;
        pa = wa;
        cmd = 8'h41;
      end else if (cmd == 8'h20 && dq == 8'h20) begin
        foreach (mem[i]) mem[i] = 8'hFF;
        cmd = 8'h21;
      end else begin
        if (dq == 8'hA0) ea = wa;
        cmd = dq;
      end
    end
  end

  always @(negedge supply_high) cmd = 8'h00;

  assign drv = !ce_n && !oe_n;

  always_comb begin
    if (id_voltage || cmd == 8'h90) q = addr[0] ? PART_CODE : MAKER_CODE;
    else if (cmd == 8'hA0) q = mem[ea];
    else if (cmd == 8'hC0) q = mem[pa];
    else q = mem[addr[7:0]];
  end
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_host_pkg::*;

  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  localparam int LIMIT = 20000;

  logic sys_clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_refused, supply_request;
  logic program_supply_high, identifier_high_voltage;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, m_drv;
  logic [3:0] cmd_op, r_op;
  logic [17:0] cmd_addr, flash_addr;
  logic [7:0] cmd_data, rsp_data, flash_dq_out, flash_dq_in, m_q, last_dq;
  logic [7:0] ref_mem [256];
  logic [7:0] ref_cmd, ref_pa, ref_ea, last, r_data;
  int n_errors, checks_done, cycles, seed;

  flash_host_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused),
    .supply_request(supply_request), .program_supply_high(program_supply_high),
    .identifier_high_voltage(identifier_high_voltage), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));

  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr), .dq(flash_dq_in),
    .drv(m_drv), .q(m_q), .supply_high(program_supply_high),
    .id_voltage(identifier_high_voltage));

  // an undriven bus flips every cycle so a stale byte can never be taken for data
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : (m_drv ? m_q : ~last_dq);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    last_dq <= flash_dq_in;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] rd(input logic [7:0] a);
    case (ref_cmd)
      8'h90: rd = a[0] ? PART : MAKER;
      8'hA0: rd = ref_mem[ref_ea];
      8'hC0: rd = ref_mem[ref_pa];
      default: rd = ref_mem[a];
    endcase
  endfunction

  task automatic run(input logic [3:0] op, input logic [17:0] addr, input logic [7:0] data);
    logic [7:0] exp;
    logic refd;
    int n;
    refd = op > 4'h8 || (!supply_request && op != 4'h0 && op != 4'h3);
    exp = refd ? 8'h00 : last;
    // a low supply clears the latch even when the request itself is refused
    if (!supply_request) ref_cmd = 8'h00;
    if (!refd) begin
      case (op)
        4'h0: exp = rd(addr[7:0]);
        4'h1: ref_cmd = 8'h00;
        4'h2: begin
          ref_cmd = 8'h90;
          exp = rd(addr[7:0]);
        end
        4'h3: exp = addr[0] ? PART : MAKER;
        4'h4: begin
          foreach (ref_mem[i]) ref_mem[i] = 8'hFF;
          ref_cmd = 8'h21;
        end
        4'h5: begin
          ref_ea = addr[7:0];
          ref_cmd = 8'hA0;
          exp = ref_mem[ref_ea];
        end
        4'h6: begin
          ref_mem[addr[7:0]] = ref_mem[addr[7:0]] & data;
          ref_pa = addr[7:0];
          ref_cmd = 8'h41;
        end
        4'h7: begin
          ref_cmd = 8'hC0;
          exp = ref_mem[ref_pa];
        end
        default: ref_cmd = data;
      endcase
    end
    last = exp;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_data <= data;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    check("rsp_data", rsp_data, exp);
    check("rsp_refused", {7'h00, rsp_refused}, {7'h00, refd});
  endtask

  task automatic set_supply(input logic v);
    supply_request <= v;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_addr = 18'h00000;
    cmd_data = 8'h00;
    supply_request = 1'b0;
    last_dq = 8'h00;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    seed = 28;
    for (int i = 0; i < 256; i++) ref_mem[i] = 8'(i) ^ 8'h5A;
    ref_cmd = 8'h00;
    ref_pa = 8'h00;
    ref_ea = 8'h00;
    last = 8'h00;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // every op code, first with the supply low, then high
    for (int s = 0; s < 2; s++) begin
      for (int op = 0; op < 16; op++) run(4'(op), 18'h00003 + 18'(op), 8'h00);
      set_supply(1'b1);
    end
    // random mix, the supply dropping now and then resets the latch
    for (int k = 0; k < 80; k++) begin
      set_supply(($random(seed) & 3) != 0);
      r_data = 8'($random(seed));
      r_op = 4'($unsigned($random(seed)) % 12);
      if (r_op == 4'h8) r_data = r_data[0] ? 8'h90 : 8'h00;
      run(r_op, 18'($random(seed)), r_data);
    end
    tally_and_finish();
  end
endmodule

// ---- verilog/flash_bus_cycle.sv ----
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = FLASH_ADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // cycle request from the sequencer
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // flash pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in
);

  typedef struct packed {
    eng_state_t state;
    logic [7:0] cnt;
    logic is_write;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [7:0] rdata;
    logic done;
  } eng_t;

  eng_t q;
  eng_t next_q;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    case (q.state)
      E_IDLE: begin
        if (start) begin
          next_q.is_write = is_write;
          next_q.addr = addr;
          next_q.wdata = wdata;
          next_q.ce_n = 1'b0;
          // drive data only while the output gate is still high
          next_q.dq_oe = is_write; // R19
          next_q.cnt = 8'(SETUP_CYC - 1);
          next_q.state = E_SETUP;
        end
      end
      E_SETUP: begin
        if (q.cnt == 8'h00) begin
          if (q.is_write) begin
            next_q.we_n = 1'b0; // R11
            next_q.cnt = 8'(WRITE_PULSE_CYC - 1);
          end else begin
            next_q.oe_n = 1'b0; // R1
            next_q.cnt = 8'(READ_ACCESS_CYC - 1);
          end
          next_q.state = E_STROBE;
        end else begin
          next_q.cnt = q.cnt - 8'h01;
        end
      end
      E_STROBE: begin
        if (q.cnt == 8'h00) begin
          if (q.is_write) begin
            // rising edge latches data; address and data stay put through hold
            next_q.we_n = 1'b1; // R11
          end else begin
            next_q.rdata = dq_in; // R1
            next_q.oe_n = 1'b1;
          end
          next_q.cnt = 8'(HOLD_CYC - 1);
          next_q.state = E_HOLD;
        end else begin
          next_q.cnt = q.cnt - 8'h01;
        end
      end
      E_HOLD: begin
        if (q.cnt == 8'h00) begin
          next_q.ce_n = 1'b1;
          next_q.dq_oe = 1'b0;
          next_q.done = 1'b1;
          next_q.state = E_IDLE;
        end else begin
          next_q.cnt = q.cnt - 8'h01;
        end
      end
      default: begin
        next_q.state = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '{state: E_IDLE, cnt: 8'h00, is_write: 1'b0, addr: '0, wdata: 8'h00,
             ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, rdata: 8'h00, done: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;
  assign rdata = q.rdata;
  assign ce_n = q.ce_n;
  assign oe_n = q.oe_n;
  assign we_n = q.we_n;
  assign addr_out = q.addr;
  assign dq_out = q.wdata;
  assign dq_oe = q.dq_oe;

  property p_read_gated;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == E_HOLD && $past(q.state) == E_STROBE && !q.is_write)
      |-> $past(!q.oe_n && !q.ce_n);
  endproperty
  a_read_gated: assert property (p_read_gated) else $error("read sampled without ce and oe low"); // R1

  property p_no_contention;
    @(posedge sys_clk) disable iff (!rst_n)
    q.dq_oe |-> (q.oe_n && !q.ce_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("data driven with oe low"); // R19

  property p_write_strobe;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(q.we_n) |-> !q.ce_n && q.dq_oe ##12 ($rose(q.we_n) && $stable(q.addr) && $stable(q.wdata));
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write pulse wrong"); // R11

endmodule

// ---- verilog/flash_host_ctrl.sv ----
// What the flash does and what the host must do
// R1: read data only taken while chip select and output gate are both low.
// R2: with supply high reads give array, identifier or verify data per command.
// R3: output gate high makes the flash float its data pins.
// R4: chip select high puts the flash in standby with pins floating.
// R5: deselecting the flash does not stop an erase, program or verify.
// R6: line nine at high voltage, reads at 0 and 1 give maker and part codes.
// R7: writing 90H selects identifier mode; then read at 0 or 1.
// R8: identifier mode lasts until another valid command is written.
// R9: erase and program commands only take effect with the supply high.
// R10: command latch is outside the address map; holds code, address and data.
// R11: write when strobe low with select low; address on fall, data on rise.
// R12: with supply low or at power-up the latch holds 00H.
// R13: writing 00H anywhere selects array reads until another command.
// R14: chip erase is two consecutive writes of 20H.
// R15: erase verify writes A0H with the address; next read gives check data.
// R16: program writes 40H then a write with target address and value.
// R17: program verify writes C0H; next read checks the last programmed address.
// R18: reset is two writes of FFH followed by the desired next command.
// R19: during writes output gate stays high and data pins are inputs.
// R20: after the stop timer ends a pulse the flash idles until verify or reset.
// R21: erasure runs from the second 20H rising edge to the next write.
// R22: strobes while the supply is low are ignored; latch stays at read.
// R23: command latch is a state machine stepped by write strobe edges.
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = FLASH_ADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request port
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_refused,
  // supply control
  input wire logic supply_request,
  output logic program_supply_high,
  output logic identifier_high_voltage,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);

  typedef struct packed {
    logic is_write;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } step_t;

  typedef struct packed {
    main_state_t state;
    host_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [1:0] idx;
    logic last;
    logic supply;
    logic hv;
    logic ready;
    logic start;
    logic cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic refused;
  } main_t;

  // ops that write the command latch and so need the high supply
  function automatic logic needs_supply(input logic [3:0] op);
    needs_supply = (op != OP_READ) && (op != OP_ID_HV);
  endfunction

  function automatic logic op_known(input logic [3:0] op);
    op_known = (op <= OP_RESET);
  endfunction

  function automatic step_t step_of(input host_op_t op, input logic [1:0] idx,
                                    input logic [ADDR_W-1:0] addr, input logic [7:0] data);
    step_t s;
    s = '{is_write: 1'b0, last: 1'b1, addr: addr, data: 8'h00};
    case (op)
      OP_READ: begin
        s.is_write = 1'b0;
      end
      OP_READ_MODE: begin
        s = '{is_write: 1'b1, last: 1'b1, addr: '0, data: CMD_READ_ARRAY}; // R13
      end
      OP_ID_CMD: begin
        if (idx == 2'd0) begin
          s = '{is_write: 1'b1, last: 1'b0, addr: '0, data: CMD_READ_ID}; // R7
        end
      end
      OP_ID_HV: begin
        // identifier address only; all other lines held low
        s.addr = ADDR_W'(addr[0]); // R6
      end
      OP_ERASE: begin
        s = '{is_write: 1'b1, last: (idx != 2'd0), addr: '0, data: CMD_ERASE}; // R14
      end
      OP_ERASE_VERIFY: begin
        if (idx == 2'd0) begin
          s = '{is_write: 1'b1, last: 1'b0, addr: addr, data: CMD_ERASE_VERIFY}; // R15
        end else begin
          s.addr = '0;
        end
      end
      OP_PROGRAM: begin
        if (idx == 2'd0) begin
          s = '{is_write: 1'b1, last: 1'b0, addr: '0, data: CMD_PROGRAM};
        end else begin
          s = '{is_write: 1'b1, last: 1'b1, addr: addr, data: data}; // R16
        end
      end
      OP_PROGRAM_VERIFY: begin
        if (idx == 2'd0) begin
          s = '{is_write: 1'b1, last: 1'b0, addr: '0, data: CMD_PROGRAM_VERIFY}; // R17
        end else begin
          s.addr = '0;
        end
      end
      OP_RESET: begin
        // two aborts, then the follow-up command carried in the request
        if (idx == 2'd2) begin
          s = '{is_write: 1'b1, last: 1'b1, addr: '0, data: data}; // R18
        end else begin
          s = '{is_write: 1'b1, last: 1'b0, addr: '0, data: CMD_RESET}; // R18
        end
      end
      default: begin
        s.is_write = 1'b0;
      end
    endcase
    step_of = s;
  endfunction

  main_t q;
  main_t next_q;
  step_t step;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  always_comb begin
    next_q = q;
    step = step_of(q.op, q.idx, q.addr, q.data);
    next_q.supply = supply_request;
    next_q.start = 1'b0;
    next_q.rsp_valid = 1'b0;
    case (q.state)
      M_IDLE: begin
        if (cmd_valid) begin
          next_q.ready = 1'b0;
          next_q.op = host_op_t'(cmd_op);
          next_q.addr = cmd_addr;
          next_q.data = cmd_data;
          next_q.idx = 2'd0;
          next_q.refused = 1'b0;
          // the latch ignores strobes without the high supply, so do not send them
          if (!op_known(cmd_op) || (needs_supply(cmd_op) && !q.supply)) begin
            next_q.refused = 1'b1; // R9
            next_q.rsp_data = 8'h00;
            next_q.state = M_RESP;
          end else begin
            next_q.state = M_ISSUE;
          end
        end
      end
      M_ISSUE: begin
        next_q.start = 1'b1;
        next_q.cyc_write = step.is_write;
        next_q.cyc_addr = step.addr;
        next_q.cyc_data = step.data;
        next_q.last = step.last;
        next_q.hv = (q.op == OP_ID_HV); // R6
        next_q.state = M_WAIT;
      end
      M_WAIT: begin
        if (cyc_done) begin
          if (!q.cyc_write) begin
            next_q.rsp_data = cyc_rdata; // R2
          end
          if (q.last) begin
            next_q.state = M_RESP;
          end else begin
            next_q.idx = q.idx + 2'd1;
            next_q.state = M_ISSUE;
          end
        end
      end
      M_RESP: begin
        next_q.rsp_valid = 1'b1;
        next_q.hv = 1'b0;
        next_q.ready = 1'b1;
        next_q.state = M_IDLE;
      end
      default: begin
        next_q.state = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '{state: M_IDLE, op: OP_READ, addr: '0, data: 8'h00, idx: 2'd0, last: 1'b0,
             supply: 1'b0, hv: 1'b0, ready: 1'b1, start: 1'b0, cyc_write: 1'b0,
             cyc_addr: '0, cyc_data: 8'h00, rsp_valid: 1'b0, rsp_data: 8'h00,
             refused: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  flash_bus_cycle #(
    .ADDR_W(ADDR_W)
  ) u_cycle (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(q.start),
    .is_write(q.cyc_write),
    .addr(q.cyc_addr),
    .wdata(q.cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .addr_out(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .dq_in(flash_dq_in)
  );

  assign cmd_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign rsp_refused = q.refused;
  assign program_supply_high = q.supply;
  assign identifier_high_voltage = q.hv;

  property p_id_cmd;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == M_ISSUE && q.op == OP_ID_CMD && q.idx == 2'd0)
      |=> q.start && q.cyc_write && q.cyc_data == CMD_READ_ID ##[1:80] q.start && !q.cyc_write;
  endproperty
  a_id_cmd: assert property (p_id_cmd) else $error("identifier command sequence wrong"); // R7

  property p_id_hv;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.start && q.op == OP_ID_HV) |-> q.hv && !q.cyc_write && q.cyc_addr[ADDR_W-1:1] == '0;
  endproperty
  a_id_hv: assert property (p_id_hv) else $error("identifier read without high voltage"); // R6

  property p_erase;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == M_ISSUE && q.op == OP_ERASE) |=> q.cyc_write && q.cyc_data == CMD_ERASE;
  endproperty
  a_erase: assert property (p_erase) else $error("erase write not 20H"); // R14

  property p_erase_verify;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == M_ISSUE && q.op == OP_ERASE_VERIFY && q.idx == 2'd0)
      |=> q.cyc_write && q.cyc_data == CMD_ERASE_VERIFY && q.cyc_addr == q.addr;
  endproperty
  a_erase_verify: assert property (p_erase_verify) else $error("erase verify write wrong"); // R15

  property p_program;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == M_ISSUE && q.op == OP_PROGRAM && q.idx == 2'd1)
      |=> q.cyc_write && q.cyc_addr == q.addr && q.cyc_data == q.data;
  endproperty
  a_program: assert property (p_program) else $error("program data write wrong"); // R16

  property p_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == M_ISSUE && q.op == OP_RESET)
      |=> q.cyc_write && (q.cyc_data == (q.idx == 2'd2 ? q.data : CMD_RESET));
  endproperty
  a_reset: assert property (p_reset) else $error("reset sequence wrong"); // R18

  property p_refuse;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == M_IDLE && cmd_valid && op_known(cmd_op) && needs_supply(cmd_op) && !q.supply)
      |=> q.state == M_RESP && q.refused ##1 q.rsp_valid && flash_ce_n;
  endproperty
  a_refuse: assert property (p_refuse) else $error("command sent without high supply"); // R9

endmodule

// ---- verilog/flash_host_pkg.sv ----
package flash_host_pkg;

  localparam int FLASH_ADDR_W = 18;
  localparam int FLASH_DATA_W = 8;

  // command codes written into the flash command latch
  localparam logic [7:0] CMD_READ_ARRAY = 8'h00;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // identifier addresses
  localparam logic [7:0] ID_ADDR_MAKER = 8'h00;
  localparam logic [7:0] ID_ADDR_PART = 8'h01;

  // bus cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 20;
  localparam int T_WRITE_PULSE_NS = 60;
  localparam int T_READ_ACCESS_NS = 100;
  localparam int T_HOLD_NS = 20;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host-side operation codes on the request port
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_READ_MODE = 4'h1,
    OP_ID_CMD = 4'h2,
    OP_ID_HV = 4'h3,
    OP_ERASE = 4'h4,
    OP_ERASE_VERIFY = 4'h5,
    OP_PROGRAM = 4'h6,
    OP_PROGRAM_VERIFY = 4'h7,
    OP_RESET = 4'h8
  } host_op_t;

  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_SETUP = 4'h2,
    E_STROBE = 4'h4,
    E_HOLD = 4'h8
  } eng_state_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_ISSUE = 4'h2,
    M_WAIT = 4'h4,
    M_RESP = 4'h8
  } main_state_t;

endpackage
